// [hdl/pawt_pkg.sv]
package pawt_pkg;

  // ==========================================================
  // Word geometry
  localparam int HALF_W = 16;
  localparam int SERIAL_W = 32;
  localparam int GAP_BITS = 4;
  localparam logic [4:0] LAST_DATA_IDX = 5'h1f;
  localparam logic [4:0] SYNC_BIT_IDX = 5'h07;
  localparam logic [1:0] LAST_GAP_IDX = 2'h3;

  // ==========================================================
  // Register map, byte offsets
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h4;
  localparam logic [3:0] OFS_STATE = 4'h8;

  // Status and mask bit positions
  localparam int EV_W = 3;
  localparam int EV_WORD_DONE = 0;
  localparam int EV_XFER = 1;
  localparam int EV_LOAD_ERR = 2;

  // Reset values
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [31:0] SHIFT_RST = 32'h0000_0000;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DATA = 3'b010,
    ST_GAP = 3'b100
  } pawt_state_t;

endpackage : pawt_pkg

// [hdl/pawt_transmitter.sv]
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps

// How it works
// R1 - Two captured 16-bit halves form one 32-bit word sent serially.
// R2 - Every word is followed by four gap bit periods before more data.
// R3 - Parity enabled: bit 32 is set so the whole word has odd parity.
// R4 - Parity disabled: bit 32 is bit 15 of the second half unchanged.
// R5 - Reset clears everything; gap is sent until a full word is loaded.
// R6 - One serial bit per transmit clock period.
// R7 - Host loads only while tx_ready is high.
// R8 - Host loads first half with word_select high, second with it low.
// R9 - First half bits 0-15 become serial 1-16, second half 17-32.
// R10 - Host loads with a low write pulse; capture on its rising edge.
// R11 - tx_ready drops once the second half has been captured.
// R12 - Full buffer moves to the shift register in the fourth gap bit.
// R13 - Fourth gap bit already gone: transfer next bit, tx_ready rises.
// R14 - Loads are accepted while the previous word is still shifting.
// R15 - Sync output low while tx_clock low during serial bit 8.
// R16 - Both bus symbol outputs and legacy serial data with sync exist.
// R17 - Bus symbols: one, zero, or null for idle and gap.
// R18 - One or zero in first half of a bit, null in the second half.
// R19 - After reset tx_ready is high and the first half is expected.
module pawt_transmitter (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [15:0] host_data_bus,
  input wire logic word_select,
  input wire logic write_n,
  input wire logic tx_clock,
  input wire logic parity_enable,
  input wire logic slope_select,
  output logic tx_ready,
  output logic bus_out_a,
  output logic bus_out_b,
  output logic legacy_data,
  output logic legacy_sync_n,
  output logic driver_slope,
  input wire logic [pawt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  // ==========================================================
  // Edge detection on the synchronous pins
  logic write_n_prev_reg;
  logic tx_clock_prev_reg;
  logic load_strobe;
  logic bit_edge;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      write_n_prev_reg <= 1'b1;
      tx_clock_prev_reg <= 1'b0;
    end else if (clk_en) begin
      write_n_prev_reg <= write_n;
      tx_clock_prev_reg <= tx_clock;
    end
  end

  assign load_strobe = write_n & ~write_n_prev_reg; // R10
  assign bit_edge = tx_clock & ~tx_clock_prev_reg; // R6

  // ==========================================================
  // Input buffer: two halves
  logic [15:0] first_half_reg;
  logic [15:0] second_half_reg;
  logic first_held_reg;
  logic buf_full_reg;
  logic transfer;
  logic load_first;
  logic load_second;
  logic load_err;

  // Loads while full are dropped, so a misbehaving host cannot corrupt a staged word
  assign load_first = load_strobe & ~buf_full_reg & word_select; // R8
  assign load_second = load_strobe & ~buf_full_reg & ~word_select & first_held_reg; // R8
  assign load_err = load_strobe & ~load_first & ~load_second; // R7

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      first_half_reg <= pawt_pkg::WORD_RST;
      second_half_reg <= pawt_pkg::WORD_RST;
    end else if (clk_en) begin
      if (load_first) begin
        first_half_reg <= host_data_bus; // R10
      end
      if (load_second) begin
        second_half_reg <= host_data_bus; // R10
      end
    end
  end

  // Capture goes on during shifting because the shift register is separate
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      first_held_reg <= 1'b0; // R19
      buf_full_reg <= 1'b0; // R19
    end else if (clk_en) begin
      if (load_first) begin
        first_held_reg <= 1'b1;
      end else if (load_second) begin
        first_held_reg <= 1'b0;
      end
      if (load_second) begin
        buf_full_reg <= 1'b1; // R11 R14
      end else if (transfer) begin
        buf_full_reg <= 1'b0; // R13
      end
    end
  end

  assign tx_ready = ~buf_full_reg; // R11 R19

  // ==========================================================
  // Sequencer and shift register
  pawt_pkg::pawt_state_t state_reg;
  logic [4:0] bit_idx_reg;
  logic [1:0] gap_idx_reg;
  logic pending_reg;
  logic [31:0] shift_reg;
  logic [31:0] staged_word;
  logic parity_bit;

  // Odd parity over bits 1..31 plus the inserted bit
  assign parity_bit = ~(^first_half_reg ^ ^second_half_reg[14:0]);
  assign staged_word = {parity_enable ? parity_bit : second_half_reg[15], // R3 R4
                        second_half_reg[14:0], first_half_reg}; // R1 R9

  // Idle counts as past the fourth gap bit, so a fresh word moves at once
  assign transfer = buf_full_reg & ~pending_reg &
                    ((state_reg == pawt_pkg::ST_IDLE) ||
                     (state_reg == pawt_pkg::ST_GAP && gap_idx_reg == pawt_pkg::LAST_GAP_IDX)); // R12 R13

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= pawt_pkg::ST_IDLE; // R5
      bit_idx_reg <= 5'h00;
      gap_idx_reg <= 2'h0;
    end else if (clk_en && bit_edge) begin
      unique case (state_reg)
        pawt_pkg::ST_IDLE: begin
          if (pending_reg) begin
            state_reg <= pawt_pkg::ST_DATA;
            bit_idx_reg <= 5'h00;
          end
        end
        pawt_pkg::ST_DATA: begin
          if (bit_idx_reg == pawt_pkg::LAST_DATA_IDX) begin
            state_reg <= pawt_pkg::ST_GAP; // R2
            gap_idx_reg <= 2'h0;
          end else begin
            bit_idx_reg <= bit_idx_reg + 5'h01; // R6
          end
        end
        pawt_pkg::ST_GAP: begin
          if (gap_idx_reg != pawt_pkg::LAST_GAP_IDX) begin
            gap_idx_reg <= gap_idx_reg + 2'h1; // R2
          end else if (pending_reg) begin
            state_reg <= pawt_pkg::ST_DATA;
            bit_idx_reg <= 5'h00;
          end else begin
            state_reg <= pawt_pkg::ST_IDLE; // R5
          end
        end
        default: begin
          state_reg <= pawt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  logic start_data;
  assign start_data = bit_edge & pending_reg &
                      ((state_reg == pawt_pkg::ST_IDLE) ||
                       (state_reg == pawt_pkg::ST_GAP && gap_idx_reg == pawt_pkg::LAST_GAP_IDX));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pending_reg <= 1'b0;
      shift_reg <= pawt_pkg::SHIFT_RST;
    end else if (clk_en) begin
      if (transfer) begin
        pending_reg <= 1'b1;
        shift_reg <= staged_word; // R12
      end else if (start_data) begin
        pending_reg <= 1'b0;
      end else if (bit_edge && state_reg == pawt_pkg::ST_DATA && bit_idx_reg != pawt_pkg::LAST_DATA_IDX) begin
        shift_reg <= {1'b0, shift_reg[31:1]}; // R9
      end
    end
  end

  // ==========================================================
  // Output drive
  logic in_data;
  assign in_data = (state_reg == pawt_pkg::ST_DATA);

  // Outputs lag the sequencer by one mclk; negligible against a bit period
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_out_a <= 1'b0; // R5
      bus_out_b <= 1'b0;
      legacy_data <= 1'b0;
      legacy_sync_n <= 1'b1;
      driver_slope <= 1'b0;
    end else if (clk_en) begin
      // Null on the bit_edge cycle: the shift register still holds the previous bit there
      bus_out_a <= in_data & tx_clock & ~bit_edge & shift_reg[0]; // R17 R18
      bus_out_b <= in_data & tx_clock & ~bit_edge & ~shift_reg[0]; // R17 R18
      legacy_data <= in_data & shift_reg[0]; // R16
      legacy_sync_n <= ~(in_data & (bit_idx_reg == pawt_pkg::SYNC_BIT_IDX) & ~tx_clock); // R15
      driver_slope <= slope_select;
    end
  end

  // ==========================================================
  // Register slave and interrupt
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [2:0] events;
  logic [2:0] clear_bits;

  assign events[pawt_pkg::EV_WORD_DONE] = bit_edge & in_data & (bit_idx_reg == pawt_pkg::LAST_DATA_IDX);
  assign events[pawt_pkg::EV_XFER] = transfer;
  assign events[pawt_pkg::EV_LOAD_ERR] = load_err;
  assign clear_bits = (reg_wr && reg_addr == pawt_pkg::OFS_STATUS) ? reg_wdata[2:0] : 3'h0;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= pawt_pkg::STATUS_RST;
    end else if (clk_en) begin
      // A new event beats a clear in the same cycle
      status_reg <= (status_reg & ~clear_bits) | events;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= pawt_pkg::MASK_RST;
    end else if (clk_en && reg_wr && reg_addr == pawt_pkg::OFS_MASK) begin
      mask_reg <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          pawt_pkg::OFS_STATUS: reg_rdata <= {29'h0, status_reg};
          pawt_pkg::OFS_MASK: reg_rdata <= {29'h0, mask_reg};
          pawt_pkg::OFS_STATE: reg_rdata <= {16'h0, 3'h0, bit_idx_reg, 1'b0, gap_idx_reg,
                                              pending_reg, first_held_reg, tx_ready, state_reg[1:0]};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_last_data_bit;
    clk_en && bit_edge && in_data && bit_idx_reg == pawt_pkg::LAST_DATA_IDX;
  endsequence

  sequence s_gap_start;
    state_reg == pawt_pkg::ST_GAP && gap_idx_reg == 2'h0;
  endsequence

  property p_ready_drops;
    clk_en && load_second |=> !tx_ready;
  endproperty
  a_ready_drops: assert property (p_ready_drops) else $error("tx_ready high after second half"); // R11

  property p_gap_follows;
    s_last_data_bit |=> s_gap_start;
  endproperty
  a_gap_follows: assert property (p_gap_follows) else $error("gap did not follow last data bit"); // R2

  property p_gap_not_short;
    clk_en && bit_edge && state_reg == pawt_pkg::ST_GAP && gap_idx_reg != pawt_pkg::LAST_GAP_IDX
      |=> state_reg == pawt_pkg::ST_GAP;
  endproperty
  a_gap_not_short: assert property (p_gap_not_short) else $error("gap left before four bits"); // R2

  property p_null_when_idle;
    clk_en && !in_data |=> !bus_out_a && !bus_out_b;
  endproperty
  a_null_when_idle: assert property (p_null_when_idle) else $error("bus driven outside data"); // R5 R17

  property p_rz_half;
    clk_en && in_data && !tx_clock |=> !bus_out_a && !bus_out_b;
  endproperty
  a_rz_half: assert property (p_rz_half) else $error("second half not null"); // R18

  property p_symbol;
    clk_en && in_data && tx_clock && !bit_edge |=> (bus_out_a != bus_out_b) && (bus_out_a == $past(shift_reg[0]));
  endproperty
  a_symbol: assert property (p_symbol) else $error("wrong symbol in first half"); // R17

  property p_sync;
    clk_en && in_data && bit_idx_reg == pawt_pkg::SYNC_BIT_IDX && !tx_clock |=> !legacy_sync_n;
  endproperty
  a_sync: assert property (p_sync) else $error("sync not low in bit 8"); // R15

  property p_one_bit_per_clock;
    clk_en && in_data && !bit_edge |=> $stable(bit_idx_reg);
  endproperty
  a_one_bit_per_clock: assert property (p_one_bit_per_clock) else $error("bit advanced without clock"); // R6

  property p_odd_parity;
    clk_en && transfer && parity_enable |=> ^shift_reg;
  endproperty
  a_odd_parity: assert property (p_odd_parity) else $error("word parity not odd"); // R3

  property p_no_parity;
    clk_en && transfer && !parity_enable |=> shift_reg[31] == $past(second_half_reg[15]) &&
      shift_reg[15:0] == $past(first_half_reg);
  endproperty
  a_no_parity: assert property (p_no_parity) else $error("bit 32 or first half wrong"); // R4 R9

  property p_ready_back;
    clk_en && transfer |=> tx_ready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("tx_ready low after transfer"); // R13

  property p_transfer_point;
    transfer |-> state_reg == pawt_pkg::ST_IDLE ||
      (state_reg == pawt_pkg::ST_GAP && gap_idx_reg == pawt_pkg::LAST_GAP_IDX);
  endproperty
  a_transfer_point: assert property (p_transfer_point) else $error("transfer outside fourth gap bit"); // R12

  property p_full_holds;
    !tx_ready && !transfer |=> !tx_ready;
  endproperty
  a_full_holds: assert property (p_full_holds) else $error("tx_ready rose without transfer"); // R11

  property p_drop_when_full;
    load_strobe && buf_full_reg |=> $stable(first_half_reg) && $stable(second_half_reg);
  endproperty
  a_drop_when_full: assert property (p_drop_when_full) else $error("staged word changed while full"); // R7

  property p_first_capture;
    clk_en && load_first |=> first_half_reg == $past(host_data_bus);
  endproperty
  a_first_capture: assert property (p_first_capture) else $error("first half not captured"); // R10 R14

  property p_second_capture;
    clk_en && load_second |=> second_half_reg == $past(host_data_bus);
  endproperty
  a_second_capture: assert property (p_second_capture) else $error("second half not captured"); // R10

  property p_idle_stays;
    clk_en && state_reg == pawt_pkg::ST_IDLE && !pending_reg |=> state_reg == pawt_pkg::ST_IDLE;
  endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("data left idle with nothing loaded"); // R5

  property p_data_start;
    clk_en && bit_edge && pending_reg && state_reg == pawt_pkg::ST_IDLE |=> in_data && bit_idx_reg == 5'h00;
  endproperty
  a_data_start: assert property (p_data_start) else $error("word did not start from idle"); // R1

  sequence s_resume_point;
    clk_en && bit_edge && pending_reg && state_reg == pawt_pkg::ST_GAP && gap_idx_reg == pawt_pkg::LAST_GAP_IDX;
  endsequence

  property p_resume;
    s_resume_point |=> in_data && bit_idx_reg == 5'h00;
  endproperty
  a_resume: assert property (p_resume) else $error("staged word did not follow the gap"); // R12

  property p_bit_advance;
    clk_en && bit_edge && in_data && bit_idx_reg != pawt_pkg::LAST_DATA_IDX
      |=> bit_idx_reg == $past(bit_idx_reg) + 5'h01;
  endproperty
  a_bit_advance: assert property (p_bit_advance) else $error("bit index did not advance by one"); // R6

endmodule : pawt_transmitter

// [verification/pawt_host_model.sv]
`timescale 1ns/1ps
module pawt_host_model (
  input wire logic mclk,
  input wire logic tx_ready,
  output logic write_n,
  output logic word_select,
  output logic [15:0] host_data_bus
);
  initial begin
    write_n = 1'b1;
    word_select = 1'b0;
    host_data_bus = 16'h0000;
  end
  // ==========================================================
  // One low pulse; after the last half the released bus shows the inverse so a late sample fails
  task automatic write_half(input logic ws, input logic [15:0] d, input logic last);
    write_n <= 1'b0;
    word_select <= ws;
    host_data_bus <= d;
    @(posedge mclk);
    write_n <= 1'b1;
    @(posedge mclk);
    if (last) begin
      word_select <= ~ws;
      host_data_bus <= ~d;
    end
  endtask : write_half
  task automatic load(input logic [15:0] w1, input logic [15:0] w2, output logic ok);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (tx_ready !== 1'b1 && n < 2000);
    ok = n < 2000;
    @(posedge mclk);
    write_half(1'b1, w1, 1'b0);
    write_half(1'b0, w2, 1'b1);
  endtask : load
endmodule : pawt_host_model

// [verification/tb_pawt_transmitter.sv]
`timescale 1ns/1ps
module tb_pawt_transmitter;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] tc_cnt = 4'h0;
  logic parity_enable = 1'b0;
  logic slope_select = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_clock, tx_ready, bus_out_a, bus_out_b, legacy_data, legacy_sync_n, driver_slope, irq;
  logic write_n, word_select, ok;
  logic [15:0] host_data_bus;
  logic [31:0] reg_rdata, rd, rx, w;
  logic [31:0] rx_q[$];
  int gap_q[$];
  int nb = 0;
  int nulls = 0;
  int bad_count = 0;
  int check_count = 0;

  always #25 mclk = ~mclk;
  // Bit clock of 16 mclk periods, high half first
  always @(posedge mclk) tc_cnt <= tc_cnt + 4'h1;
  assign tx_clock = ~tc_cnt[3];

  pawt_transmitter u_pawt_transmitter (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .host_data_bus(host_data_bus), .word_select(word_select), .write_n(write_n),
    .tx_clock(tx_clock), .parity_enable(parity_enable), .slope_select(slope_select),
    .tx_ready(tx_ready), .bus_out_a(bus_out_a), .bus_out_b(bus_out_b), .legacy_data(legacy_data),
    .legacy_sync_n(legacy_sync_n), .driver_slope(driver_slope), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  pawt_host_model u_pawt_host_model (.mclk(mclk), .tx_ready(tx_ready), .write_n(write_n),
    .word_select(word_select), .host_data_bus(host_data_bus));

  // ==========================================================
  // Compare and bus tasks
  task automatic chk_bit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    repeat (2) @(negedge mclk);
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask : reg_read
  task automatic get_word(output logic [31:0] d);
    int n;
    n = 0;
    while (rx_q.size() == 0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk_bit("word_seen", 1'b1, rx_q.size() > 0);
    d = (rx_q.size() > 0) ? rx_q.pop_front() : 32'h0;
  endtask : get_word
  function automatic logic [31:0] exp_word(input logic p, input logic [15:0] a, input logic [15:0] b);
    logic [31:0] e;
    e = {b, a};
    if (p) e[31] = ~^e[30:0];
    return e;
  endfunction : exp_word

  // ==========================================================
  // Line monitor: mid high half takes the bit, mid low half must be null
  always @(posedge mclk) begin
    if (reset_n && tc_cnt == 4'h5) begin
      if (bus_out_a || bus_out_b) begin
        if (nb == 0) gap_q.push_back(nulls);
        chk_bit("ab_both", 1'b0, bus_out_a & bus_out_b);
        chk_bit("legacy_data", bus_out_a, legacy_data);
        rx[nb] = bus_out_a;
        nb++;
        if (nb == 32) begin
          rx_q.push_back(rx);
          nb = 0;
          nulls = 0;
        end
      end else if (nb == 0) nulls++;
      else chk_bit("bit_driven", 1'b1, 1'b0);
    end
    if (reset_n && tc_cnt == 4'hd) begin
      chk_bit("null_low", 1'b0, bus_out_a | bus_out_b);
      chk_bit("sync_n", nb != 8, legacy_sync_n);
    end
  end

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    @(negedge mclk);
    chk_bit("ready_rst", 1'b1, tx_ready);
    chk_bit("sync_rst", 1'b1, legacy_sync_n);
    chk_bit("slope_rst", 1'b0, driver_slope);
    reg_read(pawt_pkg::OFS_STATUS, rd);
    chk_word("status_rst", 32'h0, rd);
    reg_read(pawt_pkg::OFS_STATE, rd);
    chk_word("state_rst", 32'h0000_0005, rd);
    @(negedge mclk);
    chk_word("rdata_back", 32'h0, reg_rdata);
    reg_read(4'hc, rd);
    chk_word("unmapped", 32'h0, rd);
    @(posedge mclk);
    clk_en <= 1'b0;
    slope_select <= 1'b1;
    repeat (20) @(negedge mclk);
    chk_bit("slope_frozen", 1'b0, driver_slope);
    @(posedge mclk);
    clk_en <= 1'b1;
    repeat (100) @(posedge mclk);
    chk_bit("slope", 1'b1, driver_slope);
    chk_bit("idle_gap", 1'b1, rx_q.size() == 0 && nb == 0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_word(input logic p, input logic [15:0] a, input logic [15:0] b);
    int n;
    repeat (80) @(posedge mclk);
    parity_enable <= p;
    u_pawt_host_model.load(a, b, ok);
    chk_bit("ready_wait", 1'b1, ok);
    n = 0;
    while (tx_ready !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk_bit("ready_again", 1'b1, tx_ready);
    get_word(w);
    chk_word("word", exp_word(p, a, b), w);
    $display("test word done");
  endtask : t_word
  task automatic t_back;
    repeat (80) @(posedge mclk);
    parity_enable <= 1'b0;
    reg_write(pawt_pkg::OFS_STATUS, 32'h7);
    reg_write(pawt_pkg::OFS_MASK, 32'h4);
    reg_read(pawt_pkg::OFS_MASK, rd);
    chk_word("mask", 32'h4, rd);
    gap_q.delete();
    u_pawt_host_model.load(16'h1111, 16'h2222, ok);
    chk_bit("ready_wait_a", 1'b1, ok);
    u_pawt_host_model.load(16'h3333, 16'hc444, ok);
    chk_bit("ready_wait_b", 1'b1, ok);
    repeat (2) @(negedge mclk);
    chk_bit("ready_full", 1'b0, tx_ready);
    @(posedge mclk);
    u_pawt_host_model.write_half(1'b1, 16'hffff, 1'b1);
    reg_read(pawt_pkg::OFS_STATUS, rd);
    chk_bit("drop_flag", 1'b1, rd[pawt_pkg::EV_LOAD_ERR]);
    chk_bit("irq_on", 1'b1, irq);
    reg_write(pawt_pkg::OFS_MASK, 32'h0);
    chk_bit("irq_masked", 1'b0, irq);
    reg_write(pawt_pkg::OFS_STATUS, 32'h4);
    reg_read(pawt_pkg::OFS_STATUS, rd);
    chk_bit("drop_clear", 1'b0, rd[pawt_pkg::EV_LOAD_ERR]);
    get_word(w);
    chk_word("word_a", exp_word(1'b0, 16'h1111, 16'h2222), w);
    get_word(w);
    chk_word("word_b", exp_word(1'b0, 16'h3333, 16'hc444), w);
    chk_word("gap", 32'd4, (gap_q.size() > 1) ? gap_q[1] : 0);
    reg_write(pawt_pkg::OFS_MASK, 32'h3);
    chk_bit("irq_events", 1'b1, irq);
    reg_write(pawt_pkg::OFS_STATUS, 32'h7);
    chk_bit("irq_clear", 1'b0, irq);
    $display("test back to back done");
  endtask : t_back

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    t_word(1'b0, 16'ha5c3, 16'h9235);
    t_word(1'b0, 16'h0f0f, 16'h1234);
    t_word(1'b1, 16'ha5c3, 16'h9235);
    t_word(1'b1, 16'h0001, 16'h8000);
    t_back;
    conclude;
  end
  // Six words plus gaps need about 3700 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("unexpected watchdog expected end seen hang");
    conclude;
  end
endmodule : tb_pawt_transmitter
